/* hw/quad_line_if_control_regs.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Overview of operation
// [RL1] global mask set blocks every interrupt
// [RL2] soft reset bit acts as hardware reset
// [RL3] host clears soft reset before other writes; here the bit self-clears and is never stored
// [RL4] bit 2 selects loss detection standard
// [RL5] bit 3 switches test pin; resets 0
// [RL6] per-channel tristate bits, reset to ones
// [RL7] control bits active high except two
// [RL8] clock and data recovery enable
// [RL9] receive jitter attenuator enable
// [RL10] transmit jitter attenuator enable
// [RL11] host never sets both attenuator bits
// [RL12] zero substitution only in single rail
// [RL13] single or dual rail select
// [RL14] data polarity select
// [RL15] receive retiming clock edge select
// [RL16] loss alarm shutdown behaviour select
// [RL17] channel powerdown bit
// [RL18] channel mask blocks its alarms
// [RL19] channel sends all ones
// [RL20] two bits pick loopback mode
// [RL21] three bits pick equalization
// [RL22] host writes zero to registers ten, eleven
// [RL23] alarms sticky, read clears gone ones
// [RL24] per-alarm mask blocks that alarm
// [RL25] host writes only zero to reserved
// [RL26] interrupt when alarm unmasked at all levels
// ****************************************
module quad_line_if_control_regs #(
    parameter int CHANNELS = quad_line_if_pkg::NUM_CH
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [quad_line_if_pkg::ADDR_W-1:0] i_addr,
    input wire logic [quad_line_if_pkg::DATA_W-1:0] i_wdata,
    output logic [quad_line_if_pkg::DATA_W-1:0] o_rdata,
    output logic o_rdata_oe,
    input wire logic [CHANNELS-1:0] i_analog_signal_loss_alarm,
    input wire logic [CHANNELS-1:0] i_digital_signal_loss_alarm,
    input wire logic [CHANNELS-1:0] i_tx_driver_monitor_alarm,
    input wire logic [CHANNELS-1:0] i_tx_clock_loss_alarm,
    input wire logic [CHANNELS-1:0] i_tx_data,
    output logic o_interrupt,
    output logic o_los_standard_select,
    output logic o_test_pin_mode,
    output logic [CHANNELS-1:0] o_driver_tristate,
    output logic o_clock_data_recovery_en,
    output logic o_rx_jitter_atten_en,
    output logic o_tx_jitter_atten_en,
    output logic o_zero_sub_en,
    output logic o_dual_rail_sel,
    output logic o_data_polarity_sel,
    output logic o_rx_retime_edge_sel,
    output logic o_los_shutdown_sel,
    output logic [CHANNELS-1:0] o_channel_powerdown,
    output logic [CHANNELS-1:0] o_all_ones_send,
    output logic [CHANNELS-1:0] o_loopback_sel_hi,
    output logic [CHANNELS-1:0] o_loopback_sel_lo,
    output logic [CHANNELS*quad_line_if_pkg::EQ_W-1:0] o_equalizer_sel,
    output logic [CHANNELS-1:0] o_tx_line_data
);
    import quad_line_if_pkg::*;

    localparam int AW = CHANNELS * ALARMS_PER_CH;

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return (a == ofs);
    endfunction

    // ****************************************
    // pin synchronisation and strobe edges
    // ****************************************
    logic [14:0] pins_s;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] wdata_s;
    logic rd_prev;
    logic wr_prev;
    logic rd_act;
    logic wr_act;
    logic rd_start;
    logic rd_end;
    logic wr_pulse;

    pin_sync #(
        .WIDTH(15),
        .RESET_VAL(PIN_RESET)
    ) u_pin_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_async({i_cs_n, i_rd_n, i_wr_n, i_addr, i_wdata}),
        .o_sync(pins_s)
    );

    assign cs_n_s = pins_s[14];
    assign rd_n_s = pins_s[13];
    assign wr_n_s = pins_s[12];
    assign addr_s = pins_s[11:8];
    assign wdata_s = pins_s[7:0];
    assign rd_act = ~cs_n_s & ~rd_n_s;
    assign wr_act = ~cs_n_s & ~wr_n_s;
    assign rd_start = rd_act & ~rd_prev;
    assign rd_end = ~rd_act & rd_prev;
    assign wr_pulse = wr_act & ~wr_prev;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rd_prev <= 1'b0;
            wr_prev <= 1'b0;
        end else begin
            rd_prev <= rd_act;
            wr_prev <= wr_act;
        end
    end

    // ****************************************
    // global control registers
    // ****************************************
    logic [7:0] gctl_a;
    logic [7:0] gctl_b;
    logic soft_rst_pending;
    logic wr_ga;
    logic wr_gb;
    logic soft_req;
    logic [7:0] next_gctl_a;
    logic [7:0] next_gctl_b;

    assign wr_ga = wr_pulse & addr_is(addr_s, OFS_GLOBAL_A);
    assign wr_gb = wr_pulse & addr_is(addr_s, OFS_GLOBAL_B);
    // [RL2] soft reset request
    assign soft_req = wr_ga & wdata_s[GA_SOFT_RESET_BIT];
    // [RL1] [RL5] [RL6] reset forced values
    assign next_gctl_a = soft_rst_pending ? GA_RESET : ((wr_ga & ~soft_req) ? wdata_s : gctl_a);
    assign next_gctl_b = soft_rst_pending ? GB_RESET : (wr_gb ? wdata_s : gctl_b);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            gctl_a <= GA_RESET;
            gctl_b <= GB_RESET;
            soft_rst_pending <= 1'b0;
        end else begin
            gctl_a <= next_gctl_a;
            gctl_b <= next_gctl_b;
            soft_rst_pending <= soft_req;
        end
    end

    // [RL4] loss standard select, not active high
    assign o_los_standard_select = gctl_a[GA_LOS_STD_BIT];
    // [RL5] test pin function
    assign o_test_pin_mode = gctl_a[GA_TEST_MODE_BIT];
    // [RL6] driver tristate per channel
    assign o_driver_tristate = gctl_a[GA_TRISTATE_LSB +: CHANNELS];
    // [RL7] [RL8] recovery enable
    assign o_clock_data_recovery_en = gctl_b[GB_CLK_RECOV_BIT];
    // [RL9] receive attenuator
    assign o_rx_jitter_atten_en = gctl_b[GB_RX_JA_BIT];
    // [RL10] transmit attenuator
    assign o_tx_jitter_atten_en = gctl_b[GB_TX_JA_BIT];
    // [RL13] rail format
    assign o_dual_rail_sel = gctl_b[GB_DUAL_RAIL_BIT];
    // [RL14] data polarity
    assign o_data_polarity_sel = gctl_b[GB_POLARITY_BIT];
    // [RL15] retiming edge
    assign o_rx_retime_edge_sel = gctl_b[GB_RETIME_BIT];
    // [RL16] shutdown select
    assign o_los_shutdown_sel = gctl_b[GB_LOS_SHUT_BIT];

    // ****************************************
    // alarm mask and channel config registers
    // ****************************************
    logic [AW-1:0] mask_vec;
    logic [7:0] chan_cfg [CHANNELS];
    logic [AW-1:0] chan_mask_exp;

    genvar k;
    generate
        for (k = 0; k < 2; k++) begin : g_mask
            logic wr_mask;
            assign wr_mask = wr_pulse & addr_is(addr_s, ADDR_W'(OFS_MASK_0 + k));
            always_ff @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    mask_vec[k*8 +: 8] <= MASK_RESET[k*8 +: 8];
                end else if (soft_rst_pending) begin
                    mask_vec[k*8 +: 8] <= MASK_RESET[k*8 +: 8];
                end else if (wr_mask) begin
                    mask_vec[k*8 +: 8] <= wdata_s;
                end
            end
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            logic wr_chan;
            assign wr_chan = wr_pulse & addr_is(addr_s, ADDR_W'(OFS_CHAN_BASE + c));
            always_ff @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    chan_cfg[c] <= CC_RESET;
                end else if (soft_rst_pending) begin
                    chan_cfg[c] <= CC_RESET;
                end else if (wr_chan) begin
                    chan_cfg[c] <= wdata_s;
                end
            end
            // [RL17] channel powerdown
            assign o_channel_powerdown[c] = chan_cfg[c][CC_POWERDOWN_BIT];
            // [RL19] all ones request
            assign o_all_ones_send[c] = chan_cfg[c][CC_ALL_ONES_BIT];
            // [RL20] loopback mode pair
            assign o_loopback_sel_hi[c] = chan_cfg[c][CC_LOOP_HI_BIT];
            assign o_loopback_sel_lo[c] = chan_cfg[c][CC_LOOP_LO_BIT];
            // [RL21] equalizer field
            assign o_equalizer_sel[c*EQ_W +: EQ_W] = chan_cfg[c][CC_EQ_LSB +: EQ_W];
            // [RL18] channel mask spread
            assign chan_mask_exp[c*ALARMS_PER_CH +: ALARMS_PER_CH] =
                {ALARMS_PER_CH{chan_cfg[c][CC_CHAN_MASK_BIT]}};
        end
    endgenerate

    // ****************************************
    // alarm status with clear on read
    // ****************************************
    logic [AW-1:0] alarm_cond;
    logic [AW-1:0] alarm_vec;
    logic [AW-1:0] rd_clr_mask;
    logic [AW-1:0] next_rd_clr_mask;
    logic [AW-1:0] alarm_clr;

    generate
        for (c = 0; c < CHANNELS; c++) begin : g_cond
            assign alarm_cond[c*ALARMS_PER_CH + AL_ANALOG_BIT] = i_analog_signal_loss_alarm[c];
            assign alarm_cond[c*ALARMS_PER_CH + AL_DIGITAL_BIT] = i_digital_signal_loss_alarm[c];
            assign alarm_cond[c*ALARMS_PER_CH + AL_DRIVER_BIT] = i_tx_driver_monitor_alarm[c];
            assign alarm_cond[c*ALARMS_PER_CH + AL_TXCLK_BIT] = i_tx_clock_loss_alarm[c];
        end
    endgenerate

    // [RL23] clear only the bits that were read as set
    assign next_rd_clr_mask = ~rd_start ? rd_clr_mask :
        addr_is(addr_s, OFS_ALARM_0) ? {{(AW-8){1'b0}}, alarm_vec[7:0]} :
        addr_is(addr_s, OFS_ALARM_1) ? {alarm_vec[AW-1:8], 8'h00} : '0;
    assign alarm_clr = rd_end ? rd_clr_mask : '0;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rd_clr_mask <= '0;
        end else begin
            rd_clr_mask <= next_rd_clr_mask;
        end
    end

    alarm_latch #(
        .WIDTH(AW)
    ) u_alarm_latch (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_init(soft_rst_pending),
        .i_cond(alarm_cond),
        .i_clr(alarm_clr),
        .o_alarm(alarm_vec)
    );

    // ****************************************
    // read data path
    // ****************************************
    logic chan_hit;
    logic [1:0] chan_idx;
    logic [ADDR_W-1:0] chan_ofs;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] next_rdata;

    assign chan_hit = (addr_s >= OFS_CHAN_BASE) && (addr_s <= OFS_CHAN_LAST);
    assign chan_ofs = addr_s - OFS_CHAN_BASE;
    assign chan_idx = chan_ofs[1:0];
    // [RL22] [RL25] clear-after-powerup and reserved registers read zero
    assign rd_mux = addr_is(addr_s, OFS_ALARM_0) ? alarm_vec[7:0] :
        addr_is(addr_s, OFS_ALARM_1) ? alarm_vec[15:8] :
        addr_is(addr_s, OFS_MASK_0) ? mask_vec[7:0] :
        addr_is(addr_s, OFS_MASK_1) ? mask_vec[15:8] :
        addr_is(addr_s, OFS_GLOBAL_A) ? gctl_a :
        addr_is(addr_s, OFS_GLOBAL_B) ? gctl_b :
        chan_hit ? chan_cfg[chan_idx] : 8'h00;
    assign next_rdata = rd_start ? rd_mux : o_rdata;
    assign o_rdata_oe = rd_act;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // ****************************************
    // interrupt and line side outputs
    // ****************************************
    logic next_irq;
    logic next_zero_sub;
    logic [CHANNELS-1:0] next_tx_line;

    // [RL1] [RL18] [RL24] [RL26] three levels of masking
    assign next_irq = ~gctl_a[GA_ALARM_MASK_BIT] & (|(alarm_vec & ~mask_vec & ~chan_mask_exp));
    // [RL12] coding valid only in single rail
    assign next_zero_sub = next_gctl_b[GB_ZERO_SUB_BIT] & ~next_gctl_b[GB_DUAL_RAIL_BIT];
    // [RL19] all ones toward the line
    assign next_tx_line = i_tx_data | o_all_ones_send;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_interrupt <= 1'b0;
            o_zero_sub_en <= 1'b0;
            o_tx_line_data <= '0;
        end else begin
            o_interrupt <= next_irq;
            o_zero_sub_en <= next_zero_sub;
            o_tx_line_data <= next_tx_line;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    AST_GLOBAL_MASK_BLOCKS: assert property ( // [RL1]
        @(posedge i_mclk) disable iff (i_rst)
        gctl_a[GA_ALARM_MASK_BIT] |=> !o_interrupt)
        else $error("interrupt raised while global mask set");

    AST_SOFT_RESET_RESTORES: assert property ( // [RL2]
        @(posedge i_mclk) disable iff (i_rst)
        soft_req |=> ##1 (gctl_a == GA_RESET && gctl_b == GB_RESET && mask_vec == MASK_RESET))
        else $error("soft reset did not restore defaults");

    AST_TRISTATE_WRITE: assert property ( // [RL6]
        @(posedge i_mclk) disable iff (i_rst)
        (wr_ga && !soft_req) |=> o_driver_tristate == $past(wdata_s[7:4]))
        else $error("tristate bits did not follow write");

    AST_ZERO_SUB_SINGLE: assert property ( // [RL12]
        @(posedge i_mclk) disable iff (i_rst)
        o_zero_sub_en |-> (!o_dual_rail_sel && gctl_b[GB_ZERO_SUB_BIT]))
        else $error("zero substitution active in dual rail");

    AST_CHAN_MASK_BLOCKS: assert property ( // [RL18]
        @(posedge i_mclk) disable iff (i_rst)
        (chan_cfg[1][CC_CHAN_MASK_BIT] && alarm_vec[3:0] == 4'h0 && alarm_vec[15:8] == 8'h00)
        |=> !o_interrupt)
        else $error("interrupt raised from a masked channel");

    AST_ALL_ONES_SENT: assert property ( // [RL19]
        @(posedge i_mclk) disable iff (i_rst)
        o_all_ones_send[0] |=> o_tx_line_data[0])
        else $error("all ones not sent on channel one");

    AST_ALARM_SET_WINS: assert property ( // [RL23]
        @(posedge i_mclk) disable iff (i_rst)
        alarm_cond[0] |=> alarm_vec[0])
        else $error("live alarm condition not latched");

    AST_ALARM_HOLDS: assert property ( // [RL23]
        @(posedge i_mclk) disable iff (i_rst)
        (alarm_vec[0] && !alarm_clr[0] && !soft_rst_pending) |=> alarm_vec[0])
        else $error("alarm bit dropped without a read");

    AST_ALARM_MASK_BLOCKS: assert property ( // [RL24]
        @(posedge i_mclk) disable iff (i_rst)
        ((alarm_vec & ~mask_vec) == '0) |=> !o_interrupt)
        else $error("interrupt raised with every set alarm masked");

    AST_IRQ_RAISED: assert property ( // [RL26]
        @(posedge i_mclk) disable iff (i_rst)
        (alarm_vec[0] && !mask_vec[0] && !chan_mask_exp[0] && !gctl_a[GA_ALARM_MASK_BIT])
        |=> o_interrupt)
        else $error("unmasked alarm did not raise interrupt");
endmodule // quad_line_if_control_regs
`default_nettype wire

/* shared/quad_line_if_pkg.sv */
`default_nettype none
// ****************************************
// register map and field layout
// ****************************************
package quad_line_if_pkg;
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int ALARMS_PER_CH = 4;
    localparam int ALARM_W = NUM_CH * ALARMS_PER_CH;

    // register offsets
    localparam logic [3:0] OFS_ALARM_0 = 4'h0;
    localparam logic [3:0] OFS_ALARM_1 = 4'h1;
    localparam logic [3:0] OFS_MASK_0 = 4'h2;
    localparam logic [3:0] OFS_MASK_1 = 4'h3;
    localparam logic [3:0] OFS_GLOBAL_A = 4'h4;
    localparam logic [3:0] OFS_GLOBAL_B = 4'h5;
    localparam logic [3:0] OFS_CHAN_BASE = 4'h6;
    localparam logic [3:0] OFS_CHAN_LAST = 4'h9;
    localparam logic [3:0] OFS_CLEAR_A = 4'hA;
    localparam logic [3:0] OFS_CLEAR_B = 4'hB;

    // global control a fields
    localparam int GA_ALARM_MASK_BIT = 0;
    localparam int GA_SOFT_RESET_BIT = 1;
    localparam int GA_LOS_STD_BIT = 2;
    localparam int GA_TEST_MODE_BIT = 3;
    localparam int GA_TRISTATE_LSB = 4;

    // global control b fields
    localparam int GB_CLK_RECOV_BIT = 0;
    localparam int GB_RX_JA_BIT = 1;
    localparam int GB_TX_JA_BIT = 2;
    localparam int GB_ZERO_SUB_BIT = 3;
    localparam int GB_DUAL_RAIL_BIT = 4;
    localparam int GB_POLARITY_BIT = 5;
    localparam int GB_RETIME_BIT = 6;
    localparam int GB_LOS_SHUT_BIT = 7;

    // channel config fields
    localparam int CC_POWERDOWN_BIT = 0;
    localparam int CC_CHAN_MASK_BIT = 1;
    localparam int CC_ALL_ONES_BIT = 2;
    localparam int CC_LOOP_LO_BIT = 3;
    localparam int CC_LOOP_HI_BIT = 4;
    localparam int CC_EQ_LSB = 5;
    localparam int EQ_W = 3;

    // alarm positions inside a channel nibble
    localparam int AL_ANALOG_BIT = 0;
    localparam int AL_DIGITAL_BIT = 1;
    localparam int AL_DRIVER_BIT = 2;
    localparam int AL_TXCLK_BIT = 3;

    // reset values
    localparam logic [7:0] GA_RESET = 8'hF1;
    localparam logic [7:0] GB_RESET = 8'h00;
    localparam logic [7:0] CC_RESET = 8'h00;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [14:0] PIN_RESET = 15'h7000;
endpackage
`default_nettype wire

/* hw/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// two-stage synchroniser for pin inputs
// ****************************************
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
        end else begin
            stage1 <= i_async;
            stage2 <= stage1;
        end
    end

    assign o_sync = stage2;
endmodule // pin_sync
`default_nettype wire

/* hw/alarm_latch.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// sticky alarm bits, clear on read
// ****************************************
module alarm_latch #(
    parameter int WIDTH = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_init,
    input wire logic [WIDTH-1:0] i_cond,
    input wire logic [WIDTH-1:0] i_clr,
    output logic [WIDTH-1:0] o_alarm
);
    logic [WIDTH-1:0] next_alarm;

    // a live condition always wins over a clear
    assign next_alarm = i_init ? i_cond : (i_cond | (o_alarm & ~i_clr));

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_alarm <= '0;
        end else begin
            o_alarm <= next_alarm;
        end
    end
endmodule // alarm_latch
`default_nettype wire

/* test/host_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// host microprocessor on the parallel bus
// ****************************************
module host_cpu_model (
    input wire logic i_mclk,
    output logic o_cs_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [quad_line_if_pkg::ADDR_W-1:0] o_addr,
    output logic [quad_line_if_pkg::DATA_W-1:0] o_wdata,
    input wire logic [quad_line_if_pkg::DATA_W-1:0] i_rdata,
    input wire logic i_rdata_oe
);
    import quad_line_if_pkg::*;
    initial begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_addr = 4'h0;
        o_wdata = 8'hA5;
    end
    // strobe held four cycles, data released to its inverse afterwards
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        o_wr_n <= 1'b0;
        o_addr <= a;
        o_wdata <= d;
        repeat (4) @(posedge i_mclk);
        o_cs_n <= 1'b1;
        o_wr_n <= 1'b1;
        o_wdata <= ~d;
        repeat (4) @(posedge i_mclk);
    endtask
    // read data taken while the strobe is still low
    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic ok);
        int i;
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        o_rd_n <= 1'b0;
        o_addr <= a;
        i = 0;
        while (i_rdata_oe !== 1'b1 && i < 10) begin
            @(posedge i_mclk);
            i++;
        end
        ok = (i < 10);
        repeat (3) @(posedge i_mclk);
        d = i_rdata;
        o_cs_n <= 1'b1;
        o_rd_n <= 1'b1;
        repeat (5) @(posedge i_mclk);
    endtask
endmodule // host_cpu_model
`default_nettype wire

/* test/test_quad_line_if_control_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module test_quad_line_if_control_regs;
    import quad_line_if_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, rd_n, wr_n, rdata_oe, intr, los_std, test_mode, clock_data_recovery_en, rxja, txja, zsub, dual;
    logic pol, retime, losshut;
    logic [3:0] addr, tristate, pdn, ones, lhi, llo, txline;
    logic [3:0] alm_a = 4'h0, alm_d = 4'h0, alm_t = 4'h0, alm_c = 4'h0, txd = 4'h0;
    logic [7:0] wdata, rdata;
    logic [11:0] eq;
    int num_errors = 0;
    int n_checks = 0;
    always #12.5 mclk = ~mclk;
    host_cpu_model host (.i_mclk(mclk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata), .i_rdata_oe(rdata_oe));
    quad_line_if_control_regs dut (.i_mclk(mclk), .i_rst(rst), .i_cs_n(cs_n), .i_rd_n(rd_n),
        .i_wr_n(wr_n), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rdata_oe(rdata_oe),
        .i_analog_signal_loss_alarm(alm_a), .i_digital_signal_loss_alarm(alm_d),
        .i_tx_driver_monitor_alarm(alm_t), .i_tx_clock_loss_alarm(alm_c), .i_tx_data(txd),
        .o_interrupt(intr), .o_los_standard_select(los_std), .o_test_pin_mode(test_mode),
        .o_driver_tristate(tristate), .o_clock_data_recovery_en(clock_data_recovery_en),
        .o_rx_jitter_atten_en(rxja), .o_tx_jitter_atten_en(txja), .o_zero_sub_en(zsub),
        .o_dual_rail_sel(dual), .o_data_polarity_sel(pol), .o_rx_retime_edge_sel(retime),
        .o_los_shutdown_sel(losshut), .o_channel_powerdown(pdn), .o_all_ones_send(ones),
        .o_loopback_sel_hi(lhi), .o_loopback_sel_lo(llo), .o_equalizer_sel(eq),
        .o_tx_line_data(txline));
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        logic ok;
        host.rd(a, d, ok);
        if (!ok) begin
            num_errors++;
            end_sim();
        end
    endtask
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(name, {8'h00, d}, {8'h00, exp});
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_values();
        chk("tristate", {12'h0, tristate}, 16'h000F);
        chk("test_mode", {15'h0, test_mode}, 16'h0000);
        rd_chk("ga", OFS_GLOBAL_A, 8'hF1);
        rd_chk("gb", OFS_GLOBAL_B, 8'h00);
    endtask
    task automatic t_global_a();
        host.wr(OFS_GLOBAL_A, 8'h00);
        host.wr(OFS_GLOBAL_A, 8'h5C);
        rd_chk("ga", OFS_GLOBAL_A, 8'h5C);
        chk("tristate", {12'h0, tristate}, 16'h0005);
        chk("los_std", {15'h0, los_std}, 16'h0001);
        chk("test_mode", {15'h0, test_mode}, 16'h0001);
    endtask
    task automatic t_global_b();
        logic [7:0] v;
        for (int b = 0; b < 8; b++) begin
            // one global control b bit at a time
            host.wr(OFS_GLOBAL_B, 8'h01 << b);
            v = {losshut, retime, pol, dual, zsub, txja, rxja, clock_data_recovery_en};
            chk("gb_out", {8'h0, v}, {8'h0, 8'h01 << b});
            rd_chk("gb", OFS_GLOBAL_B, 8'h01 << b);
        end
        host.wr(OFS_GLOBAL_B, 8'h18);
        chk("zsub_dual", {15'h0, zsub}, 16'h0000);
        chk("dual", {15'h0, dual}, 16'h0001);
    endtask
    task automatic t_channels();
        logic [7:0] val [4] = '{8'h25, 8'h5A, 8'hB4, 8'hE9};
        logic [3:0] e_p, e_o, e_l, e_h;
        logic [11:0] e_q;
        for (int c = 0; c < 4; c++) begin
            host.wr(OFS_CHAN_BASE + 4'(c), val[c]);
            e_p[c] = val[c][0];
            e_o[c] = val[c][2];
            e_l[c] = val[c][3];
            e_h[c] = val[c][4];
            e_q[3*c +: 3] = val[c][7:5];
        end
        for (int c = 0; c < 4; c++) rd_chk("cc", OFS_CHAN_BASE + 4'(c), val[c]);
        chk("pdn", {12'h0, pdn}, {12'h0, e_p});
        chk("ones", {12'h0, ones}, {12'h0, e_o});
        chk("loop_lo", {12'h0, llo}, {12'h0, e_l});
        chk("loop_hi", {12'h0, lhi}, {12'h0, e_h});
        chk("eq", {4'h0, eq}, {4'h0, e_q});
        @(posedge mclk) txd <= 4'h2;
        repeat (3) @(posedge mclk);
        chk("txline", {12'h0, txline}, {12'h0, e_o | 4'h2});
    endtask
    task automatic t_soft_reset();
        host.wr(OFS_GLOBAL_A, 8'h02);
        rd_chk("ga", OFS_GLOBAL_A, 8'hF1);
        rd_chk("gb", OFS_GLOBAL_B, 8'h00);
        rd_chk("cc2", OFS_CHAN_BASE + 4'h1, 8'h00);
        chk("tristate", {12'h0, tristate}, 16'h000F);
    endtask
    task automatic t_other_regs();
        host.wr(OFS_CLEAR_A, 8'h00);
        host.wr(OFS_CLEAR_B, 8'h00);
        host.wr(4'hC, 8'h00);
        rd_chk("clr_a", OFS_CLEAR_A, 8'h00);
        rd_chk("rsvd", 4'hC, 8'h00);
    endtask
    task automatic t_alarms();
        host.wr(OFS_GLOBAL_A, 8'h00);
        @(posedge mclk) alm_a <= 4'h1;
        @(posedge mclk) alm_a <= 4'h0;
        repeat (3) @(posedge mclk);
        chk("intr", {15'h0, intr}, 16'h0001);
        rd_chk("alarm0", OFS_ALARM_0, 8'h01);
        rd_chk("alarm0", OFS_ALARM_0, 8'h00);
        chk("intr", {15'h0, intr}, 16'h0000);
        @(posedge mclk) alm_d <= 4'h2;
        repeat (3) @(posedge mclk);
        rd_chk("alarm0", OFS_ALARM_0, 8'h20);
        rd_chk("alarm0", OFS_ALARM_0, 8'h20);
        chk("intr", {15'h0, intr}, 16'h0001);
        host.wr(OFS_MASK_0, 8'h20);
        chk("intr", {15'h0, intr}, 16'h0000);
        host.wr(OFS_MASK_0, 8'h00);
        chk("intr", {15'h0, intr}, 16'h0001);
        host.wr(OFS_CHAN_BASE + 4'h1, 8'h02);
        chk("intr", {15'h0, intr}, 16'h0000);
        host.wr(OFS_CHAN_BASE + 4'h1, 8'h00);
        host.wr(OFS_GLOBAL_A, 8'h01);
        chk("intr", {15'h0, intr}, 16'h0000);
        @(posedge mclk) alm_d <= 4'h0;
        alm_t <= 4'h4;
        alm_c <= 4'h8;
        @(posedge mclk) alm_t <= 4'h0;
        alm_c <= 4'h0;
        repeat (3) @(posedge mclk);
        rd_chk("alarm1", OFS_ALARM_1, 8'h84);
        rd_chk("alarm1", OFS_ALARM_1, 8'h00);
        chk("intr", {15'h0, intr}, 16'h0000);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset_values();
        t_global_a();
        t_global_b();
        t_channels();
        t_soft_reset();
        t_other_regs();
        t_alarms();
        end_sim();
    end
endmodule // test_quad_line_if_control_regs
`default_nettype wire
